//--- logic/wmc_pkg.sv
// Package for the wake and mode clock switch: register map, field layout,
// reset values, stabilisation counts and the operating state encoding.
// Assumes a 32-bit Avalon-MM slave with byte addresses on word boundaries.
package wmc_pkg;

	// Register byte addresses.
	localparam logic [3:0] WMC_ADDR_MODE   = 4'h0;
	localparam logic [3:0] WMC_ADDR_CTRL   = 4'h4;
	localparam logic [3:0] WMC_ADDR_CMD    = 4'h8;

	// Clock mode register fields.
	localparam int WMC_HIGH_CLOCK_SELECT_BIT = 0;
	localparam int WMC_IDLE_ON_HALT_BIT = 1;
	localparam int WMC_HTO_BIT   = 2;
	localparam int WMC_LTO_BIT   = 3;
	localparam int WMC_FSTW_BIT  = 4;
	localparam int WMC_CKS_LSB   = 5;
	localparam logic [7:0] WMC_MODE_RESET = 8'h03;

	// Control register fields.
	localparam int WMC_SYSCLK_ON_IN_IDLE_BIT = 0;
	localparam int WMC_WDT_BIT    = 1;
	localparam int WMC_HTYPE_LSB  = 2;
	localparam int WMC_LTYPE_BIT  = 4;
	localparam logic [4:0] WMC_CTRL_RESET = 5'h00;

	// Command register field: writing one halts the core.
	localparam int WMC_HALT_BIT = 0;

	// High-speed oscillator types and low-speed oscillator types.
	localparam logic [1:0] WMC_HT_CRYSTAL = 2'h0;
	localparam logic [1:0] WMC_HT_EXT_RC  = 2'h1;
	localparam logic [1:0] WMC_HT_INT_RC  = 2'h2;
	localparam logic       WMC_LT_CRYSTAL = 1'b0;

	// Divider select: codes below this one pick the low-speed clock unless the high clock select bit is set.
	localparam logic [2:0] WMC_CKS_FIRST_HIGH = 3'h2;
	localparam logic [2:0] WMC_CKS_SHIFT_BASE = 3'h0;

	// Oscillator cycles before the ready flags rise.
	localparam logic [10:0] WMC_CNT_CRYSTAL = 11'h400;
	localparam logic [10:0] WMC_CNT_FAST_RC = 11'h010;
	localparam logic [10:0] WMC_CNT_SLOW_RC = 11'h002;

	// Operating states, one-hot.
	typedef enum logic [6:0] {
		WMC_ST_RUN   = 7'h01,
		WMC_ST_IDLE_SYSCLK_ON = 7'h02,
		WMC_ST_IDLE_SYSCLK_OFF = 7'h04,
		WMC_ST_SLP1  = 7'h08,
		WMC_ST_SLP0  = 7'h10,
		WMC_ST_WWAIT = 7'h20,
		WMC_ST_WFAST = 7'h40
	} wmc_state_t;

endpackage

//--- logic/wmc_ready_timer.sv
// Oscillator stabilisation timer: counts oscillator edges after enable.
// Assumes the tick input is a one-cycle pulse already in the system domain.
`timescale 1ns/1ps
module wmc_ready_timer (
	// Clock and reset.
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// Oscillator side.
	input  wire logic        i_enable,
	input  wire logic        i_tick,
	input  wire logic [10:0] i_target,
	// Ready flag.
	output logic             o_ready
);
	logic [10:0] cnt_q; // Edges seen since the oscillator was enabled.

	// A stopped oscillator loses its count, so every restart waits in full.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q   <= 11'h000;
			o_ready <= 1'b0;
		end else if (!i_enable) begin
			cnt_q   <= 11'h000;
			o_ready <= 1'b0;
		end else if (i_tick && !o_ready) begin
			cnt_q   <= cnt_q + 11'h001;
			o_ready <= (cnt_q + 11'h001) >= i_target;
		end
	end
endmodule // wmc_ready_timer

//--- logic/wmc_clock_switch.sv
// Wake and mode clock switch: picks the system clock source and divider,
// the idle or sleep state on halt, and fast wake-up on the sub clock.
// Assumes oscillator clocks arrive on pins asynchronous to I_SYS_CLK and are
// much slower than it; the system clock leaves as a one-cycle tick pulse.
`timescale 1ns/1ps

// Behaviour
// [RULE1] Fast wake only from halt_sub_clock_on, idle_sysclk_off.
// [RULE2] Waking from deep_halt_all_off ignores fast wake.
// [RULE3] fast_wake_enable switches fast wake-up on or off.
// [RULE4] Crystal fast wake: sub clock, then crystal.
// [RULE5] RC oscillators wake after 16 or 2 cycles.
// [RULE6] Watchdog off: no fast wake from deep halt.
// [RULE7] Halt picks idle or sleep from two bits.
// [RULE8] Low clock chosen stops high oscillator, dividers.
// [RULE9] Software enters slow running via select bits.
// [RULE10] Slow switch waits for low_osc_ready.
// [RULE11] Software returns to normal, then polls high_osc_ready.
// [RULE12] Divider select gives low clock or f_H/64..2.
// [RULE13] low_osc_ready rises after 1024 or 2 cycles.
// [RULE14] high_osc_ready low in sleep, idle_sysclk_off.
// [RULE15] Source changes only at clean tick boundaries.
module wmc_clock_switch
	import wmc_pkg::*;
(
	// System clock and reset.
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_RESETN,
	// Avalon-MM slave.
	input  wire logic [3:0]  I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	output logic [31:0]      O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST,
	// Oscillator pins and wake request.
	input  wire logic        I_HIGH_OSC_CLK,
	input  wire logic        I_SUB_OSC_CLK,
	input  wire logic        I_WAKE,
	// Clock outputs.
	output logic             O_SYS_TICK,
	output logic             O_FH16_TICK,
	output logic             O_FH64_TICK,
	output logic             O_HIGH_OSC_EN,
	output logic             O_LOW_OSC_EN,
	output logic             O_CPU_RUN
);
	logic [1:0]  rst_sync_q;   // Reset release synchroniser.
	logic        rst_n;        // Synchronised reset used by all logic.
	logic [2:0]  hi_sync_q;    // High oscillator synchroniser plus edge stage.
	logic [2:0]  lo_sync_q;    // Sub clock synchroniser plus edge stage.
	logic [1:0]  wake_sync_q;  // Wake pin synchroniser.
	logic        hi_tick;      // One pulse per high oscillator rising edge.
	logic        lo_tick;      // One pulse per sub clock rising edge.
	logic [7:0]  mode_q;       // Clock mode register, ready bits unused here.
	logic [4:0]  ctrl_q;       // Control register.
	logic        halt_q;       // Pending halt command.
	logic        wait_q;       // Avalon waitrequest.
	wmc_state_t  state_q;      // Operating state.
	logic        sel_high_q;   // System clock source: one for high speed.
	logic [5:0]  div_q;        // Divider on high oscillator ticks.
	logic        high_osc_ready;          // High oscillator ready.
	logic        low_osc_ready;          // Low oscillator ready.
	logic [10:0] hi_target;    // Stabilisation count for the high oscillator.
	logic [10:0] lo_target;    // Stabilisation count for the low oscillator.
	logic        want_high;    // Software asks for a high-speed system clock.
	logic [2:0]  cks;          // Divider select.
	logic [2:0]  shift;        // Divider power of two.
	logic [5:0]  mask;         // Divider tick mask.
	logic        hdiv_tick;    // Divided high-speed tick.
	logic        cur_tick;     // Tick of the currently selected source.
	logic        fast_ok;      // Fast wake allowed from the present state.
	logic        acc;          // Access accepted this cycle.
	logic        hi_en_d;      // Next value of the high oscillator enable.

	assign rst_n     = rst_sync_q[1];
	assign hi_tick   = hi_sync_q[1] & ~hi_sync_q[2];
	assign lo_tick   = lo_sync_q[1] & ~lo_sync_q[2];
	assign cks       = mode_q[WMC_CKS_LSB +: 3];
	assign want_high = mode_q[WMC_HIGH_CLOCK_SELECT_BIT] | (cks >= WMC_CKS_FIRST_HIGH); // see [RULE12]
	assign acc       = !wait_q && (I_AVS_READ || I_AVS_WRITE);
	// The waitrequest port is the flip-flop itself, with no logic after it.
	assign O_AVS_WAITREQUEST = wait_q;
	// High oscillator runs while it is wanted or still carries the system.
	assign hi_en_d   = (state_q == WMC_ST_RUN && (sel_high_q || want_high)) ||
		(state_q == WMC_ST_IDLE_SYSCLK_ON && sel_high_q) ||
		((state_q == WMC_ST_WWAIT || state_q == WMC_ST_WFAST) && sel_high_q);

	// Reset is asserted at once and released through two flip-flops.
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	// Pins are foreign to this clock; only the second and third stages feed logic.
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			hi_sync_q   <= 3'h0;
			lo_sync_q   <= 3'h0;
			wake_sync_q <= 2'h0;
		end else begin
			hi_sync_q   <= {hi_sync_q[1:0], I_HIGH_OSC_CLK};
			lo_sync_q   <= {lo_sync_q[1:0], I_SUB_OSC_CLK};
			wake_sync_q <= {wake_sync_q[0], I_WAKE};
		end
	end

	// Stabilisation counts follow the oscillator types.
	always_comb begin
		unique case (ctrl_q[WMC_HTYPE_LSB +: 2])
			WMC_HT_CRYSTAL: hi_target = WMC_CNT_CRYSTAL; // see [RULE4] see [RULE14]
			default:        hi_target = WMC_CNT_FAST_RC; // see [RULE5]
		endcase
		lo_target = (ctrl_q[WMC_LTYPE_BIT] == WMC_LT_CRYSTAL) ?
			WMC_CNT_CRYSTAL : WMC_CNT_SLOW_RC; // see [RULE13]
	end

	// One timer per oscillator family.
	wmc_ready_timer u_hi_timer (
		.i_clk    (I_SYS_CLK),
		.i_rst_n  (rst_n),
		.i_enable (O_HIGH_OSC_EN),
		.i_tick   (hi_tick),
		.i_target (hi_target),
		.o_ready  (high_osc_ready)
	);
	wmc_ready_timer u_lo_timer (
		.i_clk    (I_SYS_CLK),
		.i_rst_n  (rst_n),
		.i_enable (O_LOW_OSC_EN),
		.i_tick   (lo_tick),
		.i_target (lo_target),
		.o_ready  (low_osc_ready)
	);

	// Avalon slave: waitrequest drops for one cycle per request.
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			wait_q         <= 1'b1;
			O_AVS_READDATA <= 32'h0000_0000;
		end else begin
			wait_q <= !(wait_q && (I_AVS_READ || I_AVS_WRITE));
			if (wait_q && I_AVS_READ) begin
				unique case (I_AVS_ADDRESS)
					WMC_ADDR_MODE: O_AVS_READDATA <= {24'h000000, mode_q[7:4], low_osc_ready, high_osc_ready,
						mode_q[1:0]}; // see [RULE10] see [RULE11]
					WMC_ADDR_CTRL: O_AVS_READDATA <= {27'h0, ctrl_q};
					WMC_ADDR_CMD:  O_AVS_READDATA <= {25'h0, state_q};
					default:       O_AVS_READDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Register writes land at the edge where waitrequest is seen low.
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= WMC_MODE_RESET;
			ctrl_q <= WMC_CTRL_RESET;
		end else if (acc && I_AVS_WRITE) begin
			if (I_AVS_ADDRESS == WMC_ADDR_MODE) begin
				mode_q <= I_AVS_WRITEDATA[7:0]; // see [RULE9] see [RULE3]
			end
			if (I_AVS_ADDRESS == WMC_ADDR_CTRL) begin
				ctrl_q <= I_AVS_WRITEDATA[4:0];
			end
		end
	end

	// A halt command waits here until the state machine takes it.
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			halt_q <= 1'b0;
		end else if (acc && I_AVS_WRITE && I_AVS_ADDRESS == WMC_ADDR_CMD &&
			I_AVS_WRITEDATA[WMC_HALT_BIT]) begin
			halt_q <= 1'b1;
		end else if (state_q == WMC_ST_RUN) begin
			halt_q <= 1'b0;
		end
	end

	// Fast wake needs a crystal system clock, a running sub clock and the enable.
	assign fast_ok = mode_q[WMC_FSTW_BIT] && sel_high_q && // see [RULE3]
		ctrl_q[WMC_HTYPE_LSB +: 2] == WMC_HT_CRYSTAL &&   // see [RULE5]
		(state_q == WMC_ST_SLP1 || state_q == WMC_ST_IDLE_SYSCLK_OFF); // see [RULE1] see [RULE2]

	// Operating state machine.
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= WMC_ST_RUN;
		end else begin
			unique case (state_q)
				WMC_ST_RUN: begin
					if (halt_q) begin
						if (mode_q[WMC_IDLE_ON_HALT_BIT]) begin // see [RULE7]
							state_q <= ctrl_q[WMC_SYSCLK_ON_IN_IDLE_BIT] ? WMC_ST_IDLE_SYSCLK_ON : WMC_ST_IDLE_SYSCLK_OFF;
						end else begin
							// Watchdog off means both oscillators stop.
							state_q <= ctrl_q[WMC_WDT_BIT] ? WMC_ST_SLP1 : WMC_ST_SLP0;
						end
					end
				end
				WMC_ST_IDLE_SYSCLK_ON: begin
					if (wake_sync_q[1]) begin
						state_q <= WMC_ST_RUN;
					end
				end
				WMC_ST_IDLE_SYSCLK_OFF, WMC_ST_SLP1, WMC_ST_SLP0: begin
					if (wake_sync_q[1]) begin
						// Deep halt never qualifies, sub clock was stopped.
						state_q <= fast_ok ? WMC_ST_WFAST : WMC_ST_WWAIT; // see [RULE6]
					end
				end
				WMC_ST_WWAIT: begin
					if (sel_high_q ? high_osc_ready : low_osc_ready) begin // see [RULE5]
						state_q <= WMC_ST_RUN;
					end
				end
				WMC_ST_WFAST: begin
					if (high_osc_ready) begin // see [RULE4]
						state_q <= WMC_ST_RUN;
					end
				end
				default: state_q <= WMC_ST_RUN;
			endcase
		end
	end

	// Source select changes only on the outgoing source's tick, so no short
	// pulse is ever made; the new source's next tick is used unless it comes in the very next cycle.
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			sel_high_q <= 1'b1;
		end else if (state_q == WMC_ST_RUN && cur_tick) begin
			if (want_high && high_osc_ready) begin
				sel_high_q <= 1'b1; // see [RULE15]
			end else if (!want_high && low_osc_ready) begin
				sel_high_q <= 1'b0; // see [RULE10] see [RULE15]
			end
		end
	end

	// High-speed divider, kept in step with high oscillator edges.
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 6'h00;
		end else if (!O_HIGH_OSC_EN) begin
			div_q <= 6'h00;
		end else if (hi_tick) begin
			div_q <= div_q + 6'h01;
		end
	end

	// Divider mask: codes 2..7 give divide by 64 down to 2; the high clock select bit forces no division.
	always_comb begin
		shift     = mode_q[WMC_HIGH_CLOCK_SELECT_BIT] ? WMC_CKS_SHIFT_BASE : 3'(3'h0 - cks); // see [RULE12]
		mask      = 6'((7'h01 << shift) - 7'h01);
		hdiv_tick = hi_tick && ((div_q & mask) == mask);
		// During fast wake the sub clock carries the system.
		cur_tick  = (sel_high_q && state_q != WMC_ST_WFAST) ? hdiv_tick : lo_tick; // see [RULE4]
	end

	// Clock and oscillator outputs, all registered.
	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			O_SYS_TICK    <= 1'b0;
			O_FH16_TICK   <= 1'b0;
			O_FH64_TICK   <= 1'b0;
			O_HIGH_OSC_EN <= 1'b1;
			O_LOW_OSC_EN  <= 1'b1;
			O_CPU_RUN     <= 1'b0;
		end else begin
			// A tick right after another is dropped, so a source change can never
			// make two pulses one cycle apart; one tick may be lost at a switch.
			O_SYS_TICK <= cur_tick && !O_SYS_TICK && (state_q == WMC_ST_RUN ||
				state_q == WMC_ST_IDLE_SYSCLK_ON || state_q == WMC_ST_WFAST); // see [RULE15]
			// Internal dividers die with the high oscillator; gating on the next
			// enable keeps a last divided tick from outliving the enable.
			O_FH16_TICK <= hi_en_d && O_HIGH_OSC_EN && hi_tick && div_q[3:0] == 4'hF; // see [RULE8]
			O_FH64_TICK <= hi_en_d && O_HIGH_OSC_EN && hi_tick && div_q == 6'h3F;     // see [RULE8]
			// High oscillator stops once the low clock has taken over, and in
			// sleep and idle_sysclk_off, which also drops high_osc_ready.
			O_HIGH_OSC_EN <= hi_en_d; // see [RULE14] see [RULE8]
			O_LOW_OSC_EN <= state_q != WMC_ST_SLP0; // see [RULE6] see [RULE13]
			O_CPU_RUN    <= state_q == WMC_ST_RUN || state_q == WMC_ST_WFAST;
		end
	end
endmodule // wmc_clock_switch

//--- test/wmc_clock_switch_monitor.sv
// Checker for the clock switch: bus answer timing, tick shapes, halt effects.
// Assumes oscillator pins run far slower than I_SYS_CLK.
`timescale 1ns/1ps
module wmc_clock_switch_checker
	import wmc_pkg::*;
(
	input wire logic        I_SYS_CLK,
	input wire logic        I_RESETN,
	input wire logic [3:0]  I_AVS_ADDRESS,
	input wire logic        I_AVS_READ,
	input wire logic        I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic        O_AVS_WAITREQUEST,
	input wire logic        O_SYS_TICK,
	input wire logic        O_FH16_TICK,
	input wire logic        O_FH64_TICK,
	input wire logic        O_HIGH_OSC_EN,
	input wire logic        O_LOW_OSC_EN,
	input wire logic        O_CPU_RUN
);
	// One clock domain, so one default clocking and reset serve all checks.
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RESETN);
	chk_bus_answer:
	assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
		else $error("request not answered in one cycle");
	chk_bus_release:
	assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
		else $error("waitrequest low for two cycles");
	chk_fh16_stop:
	assert property (!O_HIGH_OSC_EN |-> !O_FH16_TICK) else $error("divided tick with oscillator off");
	chk_fh64_stop:
	assert property (!O_HIGH_OSC_EN |-> !O_FH64_TICK) else $error("divided tick with oscillator off");
	chk_fh16_pulse:
	assert property (O_FH16_TICK |=> !O_FH16_TICK) else $error("divided tick longer than one cycle");
	chk_tick_clean:
	assert property (O_SYS_TICK |=> !O_SYS_TICK) else $error("system tick doubled at a switch");
	chk_deep_quiet:
	assert property (!O_LOW_OSC_EN |-> !O_CPU_RUN && !O_SYS_TICK) else $error("activity in deep halt");
	chk_halt_stops:
	assert property (I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == WMC_ADDR_CMD
		&& I_AVS_WRITEDATA[WMC_HALT_BIT] && O_CPU_RUN |-> ##[1:6] !O_CPU_RUN)
		else $error("core still running after halt");
endmodule // wmc_clock_switch_checker

bind wmc_clock_switch wmc_clock_switch_checker wmc_clock_switch_checker_inst (
	.I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN), .I_AVS_ADDRESS(I_AVS_ADDRESS),
	.I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
	.O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_SYS_TICK(O_SYS_TICK), .O_FH16_TICK(O_FH16_TICK),
	.O_FH64_TICK(O_FH64_TICK), .O_HIGH_OSC_EN(O_HIGH_OSC_EN), .O_LOW_OSC_EN(O_LOW_OSC_EN),
	.O_CPU_RUN(O_CPU_RUN));

//--- test/wmc_clock_switch_tb_top.sv
// Bench for the clock switch: registers, halt states, wake-up, clock select.
// Assumes oscillator pins that toggle only while their enables are high.
`timescale 1ns/1ps
module wmc_clock_switch_tb_top import wmc_pkg::*; ;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic        waitreq;
	logic        hosc = 1'b0;
	logic        sosc = 1'b0;
	logic        wake = 1'b0;
	logic        tick, fh16, fh64, hen, len, run;
	int          bad_count = 0;
	int          comparisons = 0;
	int          cycles = 0;
	wmc_clock_switch wmc_clock_switch_inst (
		.I_SYS_CLK(clk), .I_RESETN(rst_n), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
		.I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
		.O_AVS_WAITREQUEST(waitreq), .I_HIGH_OSC_CLK(hosc), .I_SUB_OSC_CLK(sosc),
		.I_WAKE(wake), .O_SYS_TICK(tick), .O_FH16_TICK(fh16), .O_FH64_TICK(fh64),
		.O_HIGH_OSC_EN(hen), .O_LOW_OSC_EN(len), .O_CPU_RUN(run));
	always #5 clk = ~clk;
	// Oscillators step on bench clock edges: 60 ns and 200 ns periods, low when off.
	int          hcnt = 0;
	int          scnt = 0;
	always @(posedge clk) begin
		hcnt <= (hcnt == 2) ? 0 : hcnt + 1;
		scnt <= (scnt == 9) ? 0 : scnt + 1;
		if (hcnt == 2) hosc <= hen ? ~hosc : 1'b0;
		if (scnt == 9) sosc <= len ? ~sosc : 1'b0;
	end
	// Hang guard, sized well above the longest expected run.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			bad_count++;
			conclude();
		end
	end
	task automatic conclude();
		if (bad_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus cycle; the request stands until waitrequest is seen low.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdata <= d;
		// Only the bench's cycle ceiling ends this wait.
		do begin
			@(posedge clk);
		end while (waitreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// Reads until the masked value leaves v, with a bounded count.
	task automatic poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v,
		output logic [31:0] q);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 32'h0, q);
			n++;
		end while ((q & m) === v && n < 5000);
		if (n >= 5000) bad_count++;
	endtask
	task automatic halt_wake(input logic [31:0] ctl, input logic [31:0] mode,
		input logic [31:0] sh, input logic [31:0] sw);
		logic [31:0] q;
		bus(1'b1, WMC_ADDR_CTRL, ctl, q);
		bus(1'b1, WMC_ADDR_MODE, mode, q);
		poll(WMC_ADDR_MODE, 32'h04, 32'h00, q);
		bus(1'b1, WMC_ADDR_CMD, 32'h01, q);
		repeat (4) @(posedge clk);
		bus(1'b0, WMC_ADDR_CMD, 32'h0, q);
		cmp32(q, sh);
		cmp32({31'h0, len}, {31'h0, sh != 32'h10});
		bus(1'b0, WMC_ADDR_MODE, 32'h0, q);
		cmp32(q & 32'h04, (sh == 32'h02) ? 32'h04 : 32'h00);
		wake <= 1'b1;
		poll(WMC_ADDR_CMD, 32'hFF, sh, q);
		if (sw == 32'h01) poll(WMC_ADDR_CMD, 32'hFF, 32'h20, q);
		cmp32(q, sw);
		cmp32({31'h0, run}, {31'h0, sw != 32'h20});
		wake <= 1'b0;
		if (sw != 32'h01) poll(WMC_ADDR_CMD, 32'hFF, sw, q);
		cmp32(q, 32'h01);
	endtask
	task automatic s_regs();
		logic [31:0] q;
		bus(1'b0, WMC_ADDR_MODE, 32'h0, q);
		cmp32(q, {24'h0, WMC_MODE_RESET});
		bus(1'b1, 4'hC, 32'hFF, q);
		bus(1'b0, 4'hC, 32'h0, q);
		cmp32(q, 32'h0);
		bus(1'b0, WMC_ADDR_CTRL, 32'h0, q);
		cmp32(q, 32'h0);
		bus(1'b0, WMC_ADDR_CMD, 32'h0, q);
		cmp32(q, 32'h01);
	endtask
	task automatic s_halts();
		halt_wake(32'h10, 32'h13, 32'h04, 32'h40);
		halt_wake(32'h10, 32'h03, 32'h04, 32'h20);
		halt_wake(32'h12, 32'h11, 32'h08, 32'h40);
		halt_wake(32'h10, 32'h11, 32'h10, 32'h20);
		halt_wake(32'h11, 32'h03, 32'h02, 32'h01);
		halt_wake(32'h16, 32'h11, 32'h08, 32'h20);
	endtask
	// Walks every divider code; tick counts follow the chosen source.
	task automatic s_slow();
		logic [31:0] q;
		int ns, nf, n64, per, dif;
		bus(1'b1, WMC_ADDR_CTRL, 32'h10, q);
		for (int c = 0; c < 8; c++) begin
			bus(1'b1, WMC_ADDR_MODE, {24'h0, 3'(c), 5'h0}, q);
			poll(WMC_ADDR_MODE, (c < 2) ? 32'h08 : 32'h04, 32'h0, q);
			repeat (200) @(posedge clk);
			ns = 0;
			nf = 0;
			n64 = 0;
			repeat (3000) begin
				@(posedge clk);
				ns += tick;
				nf += fh16;
				n64 += fh64;
			end
			cmp32({31'h0, hen}, {31'h0, c >= 2});
			if (c < 2) cmp32(nf, 0);
			if (c < 2) cmp32(n64, 0);
			// 3000 cycles hold 500 high oscillator edges: 31 or 32 by 16, 7 or 8 by 64.
			if (c >= 2) cmp32({31'h0, nf >= 31 && nf <= 32}, 32'h1);
			if (c >= 2) cmp32({31'h0, n64 >= 7 && n64 <= 8}, 32'h1);
			per = (c < 2) ? 200 : 60 * (1 << (8 - c));
			dif = ns * per - 30000;
			cmp32({31'h0, dif <= 2 * per && dif >= -2 * per}, 32'h1);
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		s_regs();
		s_halts();
		s_slow();
		conclude();
	end
endmodule // wmc_clock_switch_tb_top
